// >>> cie_cfg.svh
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CIE_OFS_CORE_MASK 8'h00
`define CIE_OFS_GLOBAL 8'h01
`define CIE_OFS_EXT_EN 8'h02
`define CIE_OFS_PEND0 8'h03
`define CIE_OFS_PEND1 8'h04
`define CIE_OFS_PEND2 8'h05
`define CIE_OFS_IRQ_STAT 8'h06
`define CIE_OFS_IRQ_CLR 8'h07
`define CIE_OFS_IRQ_EN 8'h08
`define CIE_OFS_VECTOR 8'h09
// ------------------------------------------------------------
// Reset values and vectors
// ------------------------------------------------------------
`define CIE_RST_CORE_MASK 6'h00
`define CIE_RST_GLOBAL 1'b1
`define CIE_RST_EXT_EN 4'h0
`define CIE_VEC_RESET 6'h00
`define CIE_VEC_TRAP 6'h22
`define CIE_VEC_NMI 6'h24
`define CIE_VEC_EMU 6'h26
`define CIE_NO_SOURCE 16'h0000
// ------------------------------------------------------------
// External pin positions in the enable register
// ------------------------------------------------------------
`define CIE_EXT_PFA 0
`define CIE_EXT_PFB 1
`define CIE_EXT_ONE 2
`define CIE_EXT_TWO 3
// ------------------------------------------------------------
// Block event status bits
// ------------------------------------------------------------
`define CIE_EV_SOFT 0
`define CIE_EV_ACK 1
`define CIE_EV_WDOG 2
`endif

// >>> cie_core_irq_expansion.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cie_cfg.svh"
module cie_core_irq_expansion #(
  parameter int SRC_W = 48
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wdog_timeout,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  input wire logic power_fault_irq_a,
  input wire logic power_fault_irq_b,
  input wire logic [SRC_W-1:0] periph_req,
  input wire logic [5:0] cpu_ack,
  input wire cie_pkg::cie_op_t soft_op,
  input wire logic [5:0] soft_vector,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [5:0] core_irq_lines,
  output logic [5:0] cpu_take,
  output logic [15:0] peripheral_vector_code,
  output logic branch_valid,
  output logic [5:0] branch_vector,
  output logic global_mask_bit,
  output logic sys_reset,
  output logic irq_out
);
  // ------------------------------------------------------------
  // Source map: group.bit, core line and vector code per source
  // ------------------------------------------------------------
  // Group 0 bits 0..15 and group 2 bits 0..6 are fixed, others spare.
  function automatic logic [15:0] src_code(input int i);
    case (i)
      0: src_code = 16'h0020;
      1: src_code = 16'h0004;
      2: src_code = 16'h0001;
      3: src_code = 16'h0011;
      4: src_code = 16'h0005;
      5: src_code = 16'h0006;
      6: src_code = 16'h0007;
      7: src_code = 16'h0040;
      8: src_code = 16'h0041;
      9: src_code = 16'h0021;
      10: src_code = 16'h0022;
      11: src_code = 16'h0023;
      12: src_code = 16'h0027;
      13: src_code = 16'h0028;
      14: src_code = 16'h0029;
      15: src_code = 16'h002a;
      32: src_code = 16'h0019;
      33: src_code = 16'h0024;
      34: src_code = 16'h0025;
      35: src_code = 16'h0026;
      36: src_code = 16'h002f;
      37: src_code = 16'h0030;
      38: src_code = 16'h0031;
      default: src_code = 16'h0100 + 16'(i);
    endcase
  endfunction

  function automatic logic [2:0] src_line(input int i);
    if (i <= 8 || i == 32) begin
      src_line = 3'h0;
    end else if (i <= 15 || (i >= 33 && i <= 38)) begin
      src_line = 3'h1;
    end else if (i < 32) begin
      src_line = 3'h2;
    end else begin
      src_line = 3'h3;
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cie_pkg::cie_state_t s_q, s_d;
  logic [SRC_W-1:0] req_all;
  logic any_reset;
  logic [5:0] line_any;

  assign any_reset = !reset_n || wdog_timeout;

  always_comb begin
    req_all = periph_req;
    req_all[`CIE_EXT_PFA] = power_fault_irq_a && s_q.ext_en[`CIE_EXT_PFA];
    req_all[`CIE_EXT_ONE] = ext_irq_one && s_q.ext_en[`CIE_EXT_ONE];
    req_all[`CIE_EXT_TWO] = ext_irq_two && s_q.ext_en[`CIE_EXT_TWO];
    req_all[32] = power_fault_irq_b && s_q.ext_en[`CIE_EXT_PFB];
  end

  always_comb begin
    line_any = 6'h00;
    for (int i = 0; i < SRC_W; i++) begin
      if (s_q.pend[i]) begin
        line_any[src_line(i)] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic ack_hit;
    logic [2:0] ev;
    ack_hit = 1'b0;
    ev = 3'h0;
    s_d = s_q;
    s_d.branch.valid = 1'b0;
    s_d.rdata = 16'h0000;
    s_d.pend = s_q.pend | req_all;
    s_d.core_irq_lines = line_any;
    for (int l = 0; l < 6; l++) begin
      ack_hit = 1'b0;
      if (cpu_ack[l]) begin
        s_d.vec_code = `CIE_NO_SOURCE;
        // Lowest index is highest priority; a same-cycle request beats the ack
        // for the source it returns, so later arrivals stay pending.
        for (int i = 0; i < SRC_W; i++) begin
          if (!ack_hit && s_q.pend[i] && src_line(i) == 3'(l)) begin
            ack_hit = 1'b1;
            s_d.vec_code = src_code(i);
            s_d.pend[i] = req_all[i];
          end
        end
        ev[`CIE_EV_ACK] = 1'b1;
      end
    end
    case (soft_op)
      cie_pkg::CIE_OP_VECTORED: begin
        s_d.branch = '{1'b1, soft_vector, 1'b1};
        s_d.global_mask_bit = 1'b1;
        ev[`CIE_EV_SOFT] = 1'b1;
      end
      cie_pkg::CIE_OP_NONMASK: begin
        s_d.branch = '{1'b1, `CIE_VEC_NMI, 1'b1};
        s_d.global_mask_bit = 1'b1;
        ev[`CIE_EV_SOFT] = 1'b1;
      end
      cie_pkg::CIE_OP_TRAP: begin
        s_d.branch = '{1'b1, `CIE_VEC_TRAP, 1'b0};
        ev[`CIE_EV_SOFT] = 1'b1;
      end
      default: begin
      end
    endcase
    if (reg_wr) begin
      if (reg_addr == `CIE_OFS_CORE_MASK) begin
        s_d.core_mask = reg_wdata[5:0];
      end else if (reg_addr == `CIE_OFS_GLOBAL && soft_op == cie_pkg::CIE_OP_NONE) begin
        s_d.global_mask_bit = reg_wdata[0];
      end else if (reg_addr == `CIE_OFS_EXT_EN) begin
        s_d.ext_en = reg_wdata[3:0];
      end else if (reg_addr == `CIE_OFS_IRQ_CLR) begin
        s_d.stat = s_q.stat & ~reg_wdata[2:0];
      end else if (reg_addr == `CIE_OFS_IRQ_EN) begin
        s_d.stat_en = reg_wdata[2:0];
      end
    end
    s_d.stat = s_d.stat | ev;  // Set wins over a same-cycle clear.
    if (reg_rd) begin
      if (reg_addr == `CIE_OFS_CORE_MASK) begin
        s_d.rdata = {10'h000, s_q.core_mask};
      end else if (reg_addr == `CIE_OFS_GLOBAL) begin
        s_d.rdata = {15'h0000, s_q.global_mask_bit};
      end else if (reg_addr == `CIE_OFS_EXT_EN) begin
        s_d.rdata = {12'h000, s_q.ext_en};
      end else if (reg_addr == `CIE_OFS_PEND0) begin
        s_d.rdata = s_q.pend[15:0];
      end else if (reg_addr == `CIE_OFS_PEND1) begin
        s_d.rdata = s_q.pend[31:16];
      end else if (reg_addr == `CIE_OFS_PEND2) begin
        s_d.rdata = s_q.pend[47:32];
      end else if (reg_addr == `CIE_OFS_IRQ_STAT) begin
        s_d.rdata = {13'h0000, s_q.stat};
      end else if (reg_addr == `CIE_OFS_IRQ_EN) begin
        s_d.rdata = {13'h0000, s_q.stat_en};
      end else if (reg_addr == `CIE_OFS_VECTOR) begin
        s_d.rdata = s_q.vec_code;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Watchdog reset acts like the pin: it discards every pending
  // request and soft branch in flight rather than arbitrating.
  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      s_q <= '0;
      s_q.core_mask <= `CIE_RST_CORE_MASK;
      s_q.global_mask_bit <= `CIE_RST_GLOBAL;
      s_q.ext_en <= `CIE_RST_EXT_EN;
      s_q.stat[`CIE_EV_WDOG] <= reset_n;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign core_irq_lines = s_q.core_irq_lines;
  assign cpu_take = s_q.core_irq_lines & s_q.core_mask
                    & {6{!s_q.global_mask_bit}};
  assign peripheral_vector_code = s_q.vec_code;
  assign branch_valid = s_q.branch.valid;
  assign branch_vector = s_q.branch.vector;
  assign global_mask_bit = s_q.global_mask_bit;
  assign sys_reset = any_reset;
  assign irq_out = |(s_q.stat & s_q.stat_en);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_nmi;
    soft_op == cie_pkg::CIE_OP_NONMASK;
  endsequence
  property p_reset_clears;
    @(posedge clk_sys) any_reset |=> !branch_valid && core_irq_lines == 0;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset");
  property p_reset_masked;
    @(posedge clk_sys) any_reset |=> global_mask_bit && cpu_take == 0;
  endproperty
  a_reset_masked: assert property (p_reset_masked) else $error("mask");
  property p_wdog;
    @(posedge clk_sys) disable iff (!reset_n) wdog_timeout |=> s_q.ext_en == 0;
  endproperty
  a_wdog: assert property (p_wdog) else $error("wdog reset");
  property p_vectored;
    @(posedge clk_sys) disable iff (any_reset)
      soft_op == cie_pkg::CIE_OP_VECTORED |=>
      branch_vector == $past(soft_vector) && global_mask_bit;
  endproperty
  a_vectored: assert property (p_vectored) else $error("vectored");
  property p_nmi;
    @(posedge clk_sys) disable iff (any_reset)
      s_nmi |=> branch_valid && branch_vector == 6'h24 && global_mask_bit;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_trap;
    @(posedge clk_sys) disable iff (any_reset)
      soft_op == cie_pkg::CIE_OP_TRAP && !reg_wr |=>
      branch_vector == 6'h22 && $stable(global_mask_bit);
  endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_take;
    @(posedge clk_sys) disable iff (any_reset)
      cpu_take != 0 |-> !global_mask_bit && (cpu_take & ~core_mask_q()) == 0;
  endproperty
  function automatic logic [5:0] core_mask_q();
    return s_q.core_mask;
  endfunction
  a_take: assert property (p_take) else $error("take");
  property p_adc_code;
    @(posedge clk_sys) disable iff (any_reset)
      cpu_ack[0] && s_q.pend[1:0] == 2'b10 |=>
      peripheral_vector_code == 16'h0004;
  endproperty
  a_adc_code: assert property (p_adc_code) else $error("code");
  property p_ack_clear;
    @(posedge clk_sys) disable iff (any_reset)
      cpu_ack[0] && s_q.pend[0] && !req_all[0] |=> !s_q.pend[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack");

  // ------------------------------------------------------------
  // Checks on lines, gating and status
  // ------------------------------------------------------------
  // These watch registered copies, so each lags its cause by one edge;
  // a combinational form would race the request inputs.
  sequence s_soft_any;
    soft_op != cie_pkg::CIE_OP_NONE;
  endsequence
  sequence s_gmask_write;
    reg_wr && reg_addr == `CIE_OFS_GLOBAL
      && soft_op == cie_pkg::CIE_OP_NONE;
  endsequence
  property p_line_track;
    @(posedge clk_sys) disable iff (any_reset)
      !any_reset |=> core_irq_lines == $past(line_any);
  endproperty
  a_line_track: assert property (p_line_track)
    else $error("line");
  property p_ext_gate;
    @(posedge clk_sys) disable iff (any_reset)
      !s_q.ext_en[`CIE_EXT_PFB] && !s_q.pend[32] |=> !s_q.pend[32];
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("pin gate");
  property p_ack_status;
    @(posedge clk_sys) disable iff (any_reset)
      cpu_ack != 6'h00 |=> s_q.stat[`CIE_EV_ACK];
  endproperty
  a_ack_status: assert property (p_ack_status)
    else $error("ack status");
  property p_soft_status;
    @(posedge clk_sys) disable iff (any_reset)
      s_soft_any |=> s_q.stat[`CIE_EV_SOFT] && branch_valid;
  endproperty
  a_soft_status: assert property (p_soft_status)
    else $error("soft status");
  property p_gmask_write;
    @(posedge clk_sys) disable iff (any_reset)
      s_gmask_write |=> global_mask_bit == $past(reg_wdata[0]);
  endproperty
  a_gmask_write: assert property (p_gmask_write)
    else $error("mask write");
  property p_branch_idle;
    @(posedge clk_sys) disable iff (any_reset)
      soft_op == cie_pkg::CIE_OP_NONE |=> !branch_valid;
  endproperty
  a_branch_idle: assert property (p_branch_idle)
    else $error("branch idle");
  property p_pend_sticky;
    @(posedge clk_sys) disable iff (any_reset)
      s_q.pend[1] && cpu_ack == 6'h00 |=> s_q.pend[1];
  endproperty
  a_pend_sticky: assert property (p_pend_sticky)
    else $error("sticky");
  property p_wdog_status;
    @(posedge clk_sys) disable iff (!reset_n)
      wdog_timeout |=> s_q.stat[`CIE_EV_WDOG];
  endproperty
  a_wdog_status: assert property (p_wdog_status)
    else $error("wdog status");
  property p_vec_hold;
    @(posedge clk_sys) disable iff (any_reset)
      cpu_ack == 6'h00 |=> $stable(peripheral_vector_code);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector hold");
endmodule

// >>> cie_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core side: takes a line, then acks it
// ----------------------------------------
// The hold-off after an ack covers the cycles the line needs to fall.
module cie_cpu_model #(
  parameter int DELAY = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [5:0] cpu_take,
  output logic [5:0] cpu_ack
);
  int wait_q;
  always_ff @(posedge clk_sys) begin
    cpu_ack <= 6'h00;
    if (!reset_n || cpu_take == 6'h00) begin
      wait_q <= DELAY;
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else begin
      cpu_ack <= cpu_take & (~cpu_take + 6'h01);
      wait_q <= 3;
    end
  end
endmodule

// >>> cie_pkg.sv
package cie_pkg;
  typedef enum logic [1:0] {
    CIE_OP_NONE,
    CIE_OP_VECTORED,
    CIE_OP_NONMASK,
    CIE_OP_TRAP
  } cie_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cie_bus_t;

  typedef struct packed {
    logic valid;
    logic [5:0] vector;
    logic set_mask;
  } cie_branch_t;

  typedef struct packed {
    logic [5:0] core_mask;
    logic global_mask_bit;
    logic [3:0] ext_en;
    logic [47:0] pend;
    logic [2:0] stat;
    logic [2:0] stat_en;
    logic [15:0] rdata;
    logic [15:0] vec_code;
    logic [5:0] core_irq_lines;
    cie_branch_t branch;
  } cie_state_t;
endpackage

// >>> tb_top.sv
`timescale 1ns/1ps
`include "cie_cfg.svh"
module tb_top;
  logic clk_sys, reset_n, wdog_timeout, pin_one, pin_two, pin_a, pin_b;
  logic [47:0] periph_req;
  logic [5:0] cpu_ack, soft_vector, lines, cpu_take, branch_vector;
  cie_pkg::cie_op_t soft_op;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, vec_code;
  logic reg_wr, reg_rd, branch_valid, gmask, sys_reset, irq_out;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  cie_core_irq_expansion u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .wdog_timeout(wdog_timeout), .ext_irq_one(pin_one),
    .ext_irq_two(pin_two), .power_fault_irq_a(pin_a),
    .power_fault_irq_b(pin_b), .periph_req(periph_req), .cpu_ack(cpu_ack),
    .soft_op(soft_op), .soft_vector(soft_vector), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_irq_lines(lines), .cpu_take(cpu_take),
    .peripheral_vector_code(vec_code), .branch_valid(branch_valid),
    .branch_vector(branch_vector), .global_mask_bit(gmask),
    .sys_reset(sys_reset), .irq_out(irq_out));
  cie_cpu_model #(.DELAY(2)) u_cpu (.clk_sys(clk_sys), .reset_n(reset_n),
    .cpu_take(cpu_take), .cpu_ack(cpu_ack));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic ack_code(input logic [15:0] exp);
    int n;
    for (n = 0; n < 50 && cpu_ack === 6'h00; n++) @(posedge clk_sys) #1;
    if (n == 50) chk(16'hdead, 16'h0000);
    @(posedge clk_sys);
    #1 chk(vec_code, exp);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  cie_pkg::cie_op_t ops[4] = '{cie_pkg::CIE_OP_VECTORED,
    cie_pkg::CIE_OP_NONMASK, cie_pkg::CIE_OP_TRAP, cie_pkg::CIE_OP_VECTORED};
  logic [5:0] vecs[4] = '{6'h10, 6'h24, 6'h22, 6'h26};
  logic masks[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  initial begin
    {reset_n, wdog_timeout, pin_one, pin_two, pin_a, pin_b} = 6'h00;
    {reg_wr, reg_rd, reg_addr, reg_wdata, soft_vector} = 32'h0;
    periph_req = 48'h0;
    soft_op = cie_pkg::CIE_OP_NONE;
    cycles(10);
    reset_n <= 1'b1;
    rd(`CIE_OFS_CORE_MASK, 16'h0000);
    rd(`CIE_OFS_GLOBAL, 16'h0001);
    rd(`CIE_OFS_EXT_EN, 16'h0000);
    rd(8'h3f, 16'h0000);
    $display("test reset values done");
    periph_req[1] <= 1'b1;
    cycles(1);
    periph_req[1] <= 1'b0;
    cycles(2);
    #1 chk(16'(lines), 16'h0001);
    chk(16'(cpu_take), 16'h0000);
    wr(`CIE_OFS_CORE_MASK, 16'h0001);
    wr(`CIE_OFS_GLOBAL, 16'h0000);
    ack_code(16'h0004);
    cycles(2);
    #1 chk(16'(lines), 16'h0000);
    $display("test converter request done");
    pin_b <= 1'b1;
    cycles(3);
    #1 chk(16'(lines), 16'h0000);
    wr(`CIE_OFS_EXT_EN, 16'h0002);
    ack_code(16'h0019);
    pin_b <= 1'b0;
    cycles(10);
    $display("test pin request done");
    for (int i = 0; i < 4; i++) begin
      wr(`CIE_OFS_GLOBAL, 16'h0000);
      soft_op <= ops[i];
      soft_vector <= vecs[i];
      @(posedge clk_sys);
      soft_op <= cie_pkg::CIE_OP_NONE;
      #1 chk(16'(branch_valid), 16'h0001);
      chk(16'(branch_vector), 16'(vecs[i]));
      chk(16'(gmask), 16'(masks[i]));
    end
    $display("test soft ops done");
    rd(`CIE_OFS_IRQ_STAT, 16'h0003);
    wr(`CIE_OFS_IRQ_EN, 16'h0001);
    #1 chk(16'(irq_out), 16'h0001);
    wr(`CIE_OFS_IRQ_EN, 16'h0000);
    #1 chk(16'(irq_out), 16'h0000);
    wr(`CIE_OFS_IRQ_EN, 16'h0003);
    wr(`CIE_OFS_IRQ_CLR, 16'h0003);
    #1 chk(16'(irq_out), 16'h0000);
    rd(`CIE_OFS_IRQ_STAT, 16'h0000);
    $display("test status done");
    @(posedge clk_sys);
    wdog_timeout <= 1'b1;
    #1 chk(16'(sys_reset), 16'h0001);
    @(posedge clk_sys);
    wdog_timeout <= 1'b0;
    rd(`CIE_OFS_GLOBAL, 16'h0001);
    rd(`CIE_OFS_CORE_MASK, 16'h0000);
    rd(`CIE_OFS_IRQ_STAT, 16'h0004);
    $display("test watchdog reset done");
    report_and_stop();
  end
endmodule
